// ==== design/sdt_pkg.sv ====
// Package for the split dual 8-bit timer: offsets, fields, reset values.
// Assumes a single peripheral clock and an 8-bit register port.
package sdt_pkg;
   localparam int unsigned ADDR_W = 6;
   localparam logic [5:0] OFF_CLOCK_ENABLE_CTRL      = 6'h00;
   localparam logic [5:0] OFF_COMPARE_OUTPUT_ENABLE  = 6'h01;
   localparam logic [5:0] OFF_COMPARE_OUTPUT_VALUE   = 6'h02;
   localparam logic [5:0] OFF_SPLIT_MODE_CTRL        = 6'h03;
   localparam logic [5:0] OFF_COMMAND_CLEAR_PORT     = 6'h04;
   localparam logic [5:0] OFF_COMMAND_SET_PORT       = 6'h05;
   localparam logic [5:0] OFF_IRQ_ENABLE             = 6'h0a;
   localparam logic [5:0] OFF_IRQ_FLAGS              = 6'h0b;
   localparam logic [5:0] OFF_DEBUG_CTRL             = 6'h0e;
   localparam logic [5:0] OFF_LOW_COUNTER            = 6'h20;
   localparam logic [5:0] OFF_HIGH_COUNTER           = 6'h21;
   localparam logic [5:0] OFF_LOW_TOP                = 6'h26;
   localparam logic [5:0] OFF_HIGH_TOP               = 6'h27;
   localparam logic [5:0] OFF_MATCH_BASE             = 6'h28;
   localparam logic [5:0] OFF_MATCH_LAST             = 6'h2d;
   localparam logic [7:0] RST_ZERO                   = 8'h00;
   localparam logic [7:0] RST_TOP                    = 8'hff;
   localparam int unsigned BIT_ENABLE                = 0;
   localparam int unsigned BIT_DUAL_BYTE_SELECT      = 0;
   localparam int unsigned BIT_RUN_WHILE_HALTED      = 0;
   localparam logic [7:0] MASK_CLOCK_ENABLE_CTRL     = 8'h0f;
   localparam logic [7:0] MASK_COMPARE_OUT           = 8'h77;
   localparam logic [7:0] MASK_IRQ                   = 8'h73;
   localparam logic [3:0] MASK_COMMAND_TARGET        = 4'h3;
   localparam int unsigned PRESCALE_W                = 10;

   typedef enum logic [1:0] {
      CMD_NONE,
      CMD_RESERVED,
      CMD_RESTART,
      CMD_HARD_RESET
   } sdt_cmd_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0]        wdata;
      logic              wr;
      logic              rd;
   } sdt_bus_type;
endpackage

// ==== design/sdt_split_timer.sv ====
// Split dual 8-bit down-counting timer with register port and outputs.
// Assumes a synchronous register port and pins sampled on clk_sys.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module sdt_split_timer
   import sdt_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              rstn,
   input  wire sdt_bus_type       bus,
   output logic [7:0]             rdata,
   input  wire logic              debugHalt,
   input  wire logic [5:0]        portOutValue,
   input  wire logic              waveGenActive,
   output logic [5:0]             waveform_out_pin,
   output logic                   irqOut
);
   logic [7:0] ctrl0_q, outEn_q, outVal_q, irqEn_q, flags_q;
   logic       split_q, runDbg_q;
   logic [1:0] cmdTarget_q;
   logic [7:0] lowCnt_q, highCnt_q, lowTop_q, highTop_q;
   logic [7:0] match_q [6];
   logic [PRESCALE_W-1:0] pre_q;
   logic [5:0] wave_q;
   logic [7:0] rdata_q;
   logic       running, tick, wrHit, cmdWr;
   logic [7:0] cmdByte;
   logic [1:0] cmdTgt;
   sdt_cmd_type cmdCode;
   logic       doRestartL, doRestartH, doReset;
   logic [2:0] lowMatch, highMatch;
   logic       lowUnf, highUnf;
   logic [PRESCALE_W-1:0] preMask;
   logic [5:0] pinEn;
   logic       lowLoad, highLoad;

   assign wrHit   = bus.wr;
   assign cmdWr   = wrHit && (bus.addr == OFF_COMMAND_CLEAR_PORT ||
                              bus.addr == OFF_COMMAND_SET_PORT);
   assign cmdByte = bus.wdata;
   // The command code acts once and is never stored.
   assign cmdCode = sdt_cmd_type'(cmdByte[3:2]);
   assign cmdTgt  = cmdByte[1:0];
   // Both clear and set ports launch the written command.
   assign doRestartL = cmdWr && cmdCode == CMD_RESTART && cmdTgt[0];
   assign doRestartH = cmdWr && cmdCode == CMD_RESTART && cmdTgt[1];
   // A reset that names only one timer is honoured for that one only.
   assign doReset = cmdWr && cmdCode == CMD_HARD_RESET &&
                    !ctrl0_q[BIT_ENABLE];

   assign running = ctrl0_q[BIT_ENABLE] && (runDbg_q || !debugHalt);

   always_comb begin
      case (ctrl0_q[3:1])
         3'h0:    preMask = 10'h000;
         3'h1:    preMask = 10'h001;
         3'h2:    preMask = 10'h003;
         3'h3:    preMask = 10'h007;
         3'h4:    preMask = 10'h00f;
         3'h5:    preMask = 10'h03f;
         3'h6:    preMask = 10'h0ff;
         default: preMask = 10'h3ff;
      endcase
   end

   assign tick = running && ((pre_q & preMask) == preMask);

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pre_q <= '0;
      end else if (!running) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + 10'h001;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ctrl0_q <= RST_ZERO;
         outEn_q <= RST_ZERO;
         outVal_q <= RST_ZERO;
         split_q <= 1'b0;
         irqEn_q <= RST_ZERO;
         runDbg_q <= 1'b0;
         cmdTarget_q <= 2'h0;
      end else if (wrHit) begin
         case (bus.addr)
            OFF_CLOCK_ENABLE_CTRL:
               ctrl0_q <= bus.wdata & MASK_CLOCK_ENABLE_CTRL;
            OFF_COMPARE_OUTPUT_ENABLE:
               outEn_q <= bus.wdata & MASK_COMPARE_OUT;
            OFF_COMPARE_OUTPUT_VALUE:
               outVal_q <= bus.wdata & MASK_COMPARE_OUT;
            OFF_SPLIT_MODE_CTRL:
               split_q <= bus.wdata[BIT_DUAL_BYTE_SELECT];
            OFF_COMMAND_CLEAR_PORT:
               cmdTarget_q <= cmdTarget_q & ~bus.wdata[1:0];
            OFF_COMMAND_SET_PORT:
               cmdTarget_q <= cmdTarget_q | bus.wdata[1:0];
            OFF_IRQ_ENABLE:
               irqEn_q <= bus.wdata & MASK_IRQ;
            OFF_DEBUG_CTRL:
               runDbg_q <= bus.wdata[BIT_RUN_WHILE_HALTED];
            default: ;
         endcase
      end
   end

   // Down-counting: bottom is zero, the next tick reloads top.
   assign lowUnf  = tick && lowCnt_q == 8'h00;
   assign highUnf = tick && highCnt_q == 8'h00;
   // Loads that may move a counter while the unit is stopped.
   assign lowLoad  = (wrHit && bus.addr == OFF_LOW_COUNTER) || doRestartL ||
                     (doReset && cmdTgt[0]);
   assign highLoad = (wrHit && bus.addr == OFF_HIGH_COUNTER) || doRestartH ||
                     (doReset && cmdTgt[1]);

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         lowCnt_q <= RST_ZERO;
      end else if (wrHit && bus.addr == OFF_LOW_COUNTER) begin
         lowCnt_q <= bus.wdata;
      end else if ((doReset && cmdTgt[0]) || doRestartL) begin
         lowCnt_q <= RST_ZERO;
      end else if (lowUnf) begin
         lowCnt_q <= lowTop_q;
      end else if (tick) begin
         lowCnt_q <= lowCnt_q - 8'h01;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         highCnt_q <= RST_ZERO;
      end else if (wrHit && bus.addr == OFF_HIGH_COUNTER) begin
         highCnt_q <= bus.wdata;
      end else if ((doReset && cmdTgt[1]) || doRestartH) begin
         highCnt_q <= RST_ZERO;
      end else if (highUnf) begin
         highCnt_q <= highTop_q;
      end else if (tick) begin
         highCnt_q <= highCnt_q - 8'h01;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         lowTop_q <= RST_TOP;
         highTop_q <= RST_TOP;
         for (int i = 0; i < 6; i++) match_q[i] <= RST_ZERO;
      end else if (doReset) begin
         if (cmdTgt[0]) lowTop_q <= RST_TOP;
         if (cmdTgt[1]) highTop_q <= RST_TOP;
         for (int i = 0; i < 6; i++) begin
            if (cmdTgt[i%2]) match_q[i] <= RST_ZERO;
         end
      end else if (wrHit) begin
         if (bus.addr == OFF_LOW_TOP) lowTop_q <= bus.wdata;
         if (bus.addr == OFF_HIGH_TOP) highTop_q <= bus.wdata;
         for (int i = 0; i < 6; i++) begin
            if (bus.addr == OFF_MATCH_BASE + 6'(i)) match_q[i] <= bus.wdata;
         end
      end
   end

   // Even slots hold low channels, odd slots high channels.
   for (genvar c = 0; c < 3; c++) begin : g_cmp
      assign lowMatch[c]  = lowCnt_q == match_q[2*c];
      assign highMatch[c] = highCnt_q == match_q[2*c+1];
   end

   // Flags: hardware set wins over a software clear in the same cycle.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         flags_q <= RST_ZERO;
      end else begin
         flags_q <= ((flags_q & ~((wrHit && bus.addr == OFF_IRQ_FLAGS) ?
                                  bus.wdata : 8'h00))
                     | {1'b0, lowMatch, 2'b00, highUnf, lowUnf})
                    & MASK_IRQ;
      end
   end

   assign irqOut = |(flags_q & irqEn_q);

   // A match on a tick sets the pin and underflow clears it while enabled; disabled, the value bits.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wave_q <= 6'h00;
      end else if (!ctrl0_q[BIT_ENABLE]) begin
         wave_q <= {outVal_q[6:4], outVal_q[2:0]};
      end else if (tick) begin
         for (int c = 0; c < 3; c++) begin
            if (lowMatch[c]) wave_q[c] <= 1'b1;
            if (highMatch[c]) wave_q[c+3] <= 1'b1;
         end
         if (lowUnf) wave_q[2:0] <= 3'h0;
         if (highUnf) wave_q[5:3] <= 3'h0;
      end
   end

   assign pinEn = {outEn_q[6:4], outEn_q[2:0]};
   always_comb begin
      for (int c = 0; c < 6; c++) begin
         waveform_out_pin[c] =
            (waveGenActive && pinEn[c]) ?
            wave_q[c] : portOutValue[c];
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= RST_ZERO;
      end else if (bus.rd) begin
         case (bus.addr)
            OFF_CLOCK_ENABLE_CTRL:     rdata_q <= ctrl0_q;
            OFF_COMPARE_OUTPUT_ENABLE: rdata_q <= outEn_q;
            OFF_COMPARE_OUTPUT_VALUE:  rdata_q <= outVal_q;
            OFF_SPLIT_MODE_CTRL:       rdata_q <= {7'h00, split_q};
            OFF_COMMAND_CLEAR_PORT,
            OFF_COMMAND_SET_PORT:      rdata_q <= {6'h00, cmdTarget_q};
            OFF_IRQ_ENABLE:            rdata_q <= irqEn_q;
            OFF_IRQ_FLAGS:             rdata_q <= flags_q;
            OFF_DEBUG_CTRL:            rdata_q <= {7'h00, runDbg_q};
            OFF_LOW_COUNTER:           rdata_q <= lowCnt_q;
            OFF_HIGH_COUNTER:          rdata_q <= highCnt_q;
            OFF_LOW_TOP:               rdata_q <= lowTop_q;
            OFF_HIGH_TOP:              rdata_q <= highTop_q;
            default: begin
               if (bus.addr >= OFF_MATCH_BASE && bus.addr <= OFF_MATCH_LAST)
                  rdata_q <= match_q[3'(bus.addr - OFF_MATCH_BASE)];
               else
                  rdata_q <= RST_ZERO;
            end
         endcase
      end else begin
         rdata_q <= RST_ZERO;
      end
   end
   assign rdata = rdata_q;

   property p_flag_sticky;
      @(posedge clk_sys) disable iff (!rstn)
      flags_q[0] && !(wrHit && bus.addr == OFF_IRQ_FLAGS && bus.wdata[0])
      |=> flags_q[0];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("Low underflow flag dropped without a clear.");

   property p_low_unf;
      @(posedge clk_sys) disable iff (!rstn) lowUnf |=> flags_q[0];
   endproperty
   a_low_unf: assert property (p_low_unf)
      else $error("Low underflow flag not set.");

   property p_high_unf;
      @(posedge clk_sys) disable iff (!rstn) highUnf |=> flags_q[1];
   endproperty
   a_high_unf: assert property (p_high_unf)
      else $error("High underflow flag not set.");

   property p_cmp_flag;
      @(posedge clk_sys) disable iff (!rstn) lowMatch[0] |=> flags_q[4];
   endproperty
   a_cmp_flag: assert property (p_cmp_flag)
      else $error("Compare flag not set on match.");

   property p_stopped;
      @(posedge clk_sys) disable iff (!rstn)
      !ctrl0_q[BIT_ENABLE] |=> $stable(lowCnt_q) || $past(lowLoad);
   endproperty
   a_stopped: assert property (p_stopped)
      else $error("Counter moved while disabled.");

   property p_cnt_wr;
      @(posedge clk_sys) disable iff (!rstn)
      wrHit && bus.addr == OFF_LOW_COUNTER |=> lowCnt_q == $past(bus.wdata);
   endproperty
   a_cnt_wr: assert property (p_cnt_wr)
      else $error("Counter write lost.");

   property p_reload;
      @(posedge clk_sys) disable iff (!rstn)
      lowUnf && !(wrHit && bus.addr == OFF_LOW_COUNTER) && !cmdWr
      |=> lowCnt_q == $past(lowTop_q);
   endproperty
   a_reload: assert property (p_reload)
      else $error("Low counter did not reload top.");

   property p_cmd_zero;
      @(posedge clk_sys) disable iff (!rstn)
      bus.rd && bus.addr == OFF_COMMAND_SET_PORT |=> rdata[3:2] == 2'h0;
   endproperty
   a_cmd_zero: assert property (p_cmd_zero)
      else $error("Command field read nonzero.");

   // The forced level lands one cycle late, so two stopped cycles are needed.
   sequence s_held_stopped;
      !ctrl0_q[BIT_ENABLE] ##1 !ctrl0_q[BIT_ENABLE];
   endsequence

   property p_forced;
      @(posedge clk_sys) disable iff (!rstn)
      s_held_stopped |-> wave_q[0] == $past(outVal_q[0]);
   endproperty
   a_forced: assert property (p_forced)
      else $error("Forced output level not applied.");

   property p_reset_ignored;
      @(posedge clk_sys) disable iff (!rstn)
      cmdWr && cmdCode == CMD_HARD_RESET && ctrl0_q[BIT_ENABLE]
      |=> $stable(lowTop_q) && $stable(highTop_q);
   endproperty
   a_reset_ignored: assert property (p_reset_ignored)
      else $error("Hard reset acted while enabled.");

   property p_restart_low;
      @(posedge clk_sys) disable iff (!rstn) doRestartL |=> lowCnt_q == 8'h00;
   endproperty
   a_restart_low: assert property (p_restart_low)
      else $error("Low restart did not clear the counter.");

   property p_restart_high;
      @(posedge clk_sys) disable iff (!rstn) doRestartH |=> highCnt_q == 8'h00;
   endproperty
   a_restart_high: assert property (p_restart_high)
      else $error("High restart did not clear the counter.");

   property p_set_port;
      @(posedge clk_sys) disable iff (!rstn)
      wrHit && bus.addr == OFF_COMMAND_SET_PORT
      |=> cmdTarget_q == ($past(cmdTarget_q) | $past(cmdTgt));
   endproperty
   a_set_port: assert property (p_set_port)
      else $error("Set port did not set target bits.");

   property p_clr_port;
      @(posedge clk_sys) disable iff (!rstn)
      wrHit && bus.addr == OFF_COMMAND_CLEAR_PORT
      |=> cmdTarget_q == ($past(cmdTarget_q) & ~$past(cmdTgt));
   endproperty
   a_clr_port: assert property (p_clr_port)
      else $error("Clear port did not clear target bits.");

   property p_irq_gate;
      @(posedge clk_sys) disable iff (!rstn)
      flags_q[1] && irqEn_q[1] |-> irqOut;
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("Enabled flag raised no interrupt.");

   property p_debug_halt;
      @(posedge clk_sys) disable iff (!rstn)
      debugHalt && !runDbg_q |=> $stable(lowCnt_q) || $past(lowLoad);
   endproperty
   a_debug_halt: assert property (p_debug_halt)
      else $error("Counter moved during debug halt.");

   property p_high_stopped;
      @(posedge clk_sys) disable iff (!rstn)
      !ctrl0_q[BIT_ENABLE] |=> $stable(highCnt_q) || $past(highLoad);
   endproperty
   a_high_stopped: assert property (p_high_stopped)
      else $error("High counter moved while disabled.");
endmodule // sdt_split_timer

// ==== dv/sdt_split_timer_test.sv ====
// Self-checking bench for the split dual 8-bit timer.
// Assumes the register port answers a read in the cycle after the strobe.
`timescale 1ns/1ps
module sdt_split_timer_test
   import sdt_pkg::*;
;
   logic        clk_sys;
   logic        rstn;
   sdt_bus_type bus;
   logic [7:0]  rdata;
   logic        debugHalt;
   logic [5:0]  portOutValue;
   logic        waveGenActive;
   logic [5:0]  pins;
   logic        irqOut;
   int          errCount;
   int          checked;

   sdt_split_timer dut (
      .clk_sys          (clk_sys),
      .rstn             (rstn),
      .bus              (bus),
      .rdata            (rdata),
      .debugHalt        (debugHalt),
      .portOutValue     (portOutValue),
      .waveGenActive    (waveGenActive),
      .waveform_out_pin (pins),
      .irqOut           (irqOut)
   );

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus.addr  <= a;
      bus.wdata <= d;
      bus.wr    <= 1'b1;
      @(posedge clk_sys);
      bus.wr <= 1'b0;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         errCount++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // The read data stand for one cycle only, so they are taken just after
   // the edge that accepted the strobe.
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      bus.addr <= a;
      bus.rd   <= 1'b1;
      @(posedge clk_sys);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic crd(input logic [5:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(d, exp);
   endtask

   // Writing 0x04 or 0x05 runs commands, so those two are left to t_cmd.
   task automatic t_regs();
      logic [5:0] a [11] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h0a, 6'h0e,
                             6'h20, 6'h21, 6'h26, 6'h28, 6'h07};
      logic [7:0] m [11] = '{8'h0f, 8'h77, 8'h77, 8'h01, 8'h73, 8'h01,
                             8'hff, 8'hff, 8'hff, 8'hff, 8'h00};
      logic [7:0] r [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                             8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
      #1 chk({2'b00, pins}, 8'h2a);
      for (int i = 0; i < 11; i++) begin
         crd(a[i], r[i]);
         wr(a[i], 8'hff);
         crd(a[i], m[i]);
         wr(a[i], r[i]);
      end
      #1 chk({7'h00, irqOut}, 8'h00);
   endtask

   task automatic t_prescale();
      int         dv [8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
      logic [7:0] l;
      logic [7:0] h;
      for (int k = 0; k < 8; k++) begin
         wr(6'h20, 8'h80);
         wr(6'h21, 8'h80);
         wr(6'h00, {4'h0, k[2:0], 1'b1});
         repeat (8 * dv[k] - 2) @(posedge clk_sys);
         wr(6'h00, 8'h00);
         rd(6'h20, l);
         rd(6'h21, h);
         chk(l, 8'h78);
         chk(h, 8'h78);
      end
   endtask

   task automatic t_under();
      wr(6'h28, 8'h80);
      wr(6'h2a, 8'h80);
      wr(6'h2c, 8'h80);
      wr(6'h26, 8'h03);
      wr(6'h27, 8'h05);
      wr(6'h20, 8'h02);
      wr(6'h21, 8'h02);
      wr(6'h0b, 8'h73);
      wr(6'h00, 8'h01);
      wr(6'h00, 8'h00);
      crd(6'h0b, 8'h00);
      crd(6'h20, 8'h00);
      wr(6'h00, 8'h01);
      wr(6'h00, 8'h00);
      crd(6'h0b, 8'h03);
      crd(6'h20, 8'h02);
      crd(6'h21, 8'h04);
      #1 chk({7'h00, irqOut}, 8'h00);
      wr(6'h0a, 8'h02);
      #1 chk({7'h00, irqOut}, 8'h01);
      wr(6'h0b, 8'h02);
      #1 chk({7'h00, irqOut}, 8'h00);
      crd(6'h0b, 8'h01);
      wr(6'h0a, 8'h00);
      wr(6'h00, 8'h01);
      wr(6'h20, 8'h40);
      wr(6'h00, 8'h00);
      crd(6'h20, 8'h3e);
      @(posedge clk_sys);
      debugHalt <= 1'b1;
      wr(6'h20, 8'h50);
      wr(6'h00, 8'h01);
      wr(6'h00, 8'h00);
      crd(6'h20, 8'h50);
      wr(6'h0e, 8'h01);
      wr(6'h00, 8'h01);
      wr(6'h00, 8'h00);
      crd(6'h20, 8'h4e);
      wr(6'h0e, 8'h00);
      @(posedge clk_sys);
      debugHalt <= 1'b0;
   endtask

   task automatic t_compare();
      logic [7:0] e;
      e = 8'h00;
      wr(6'h28, 8'h10);
      wr(6'h2a, 8'h11);
      wr(6'h2c, 8'h12);
      wr(6'h20, 8'h20);
      wr(6'h21, 8'h10);
      wr(6'h0b, 8'h73);
      crd(6'h0b, 8'h00);
      for (int c = 0; c < 3; c++) begin
         wr(6'h20, 8'h10 + 8'(c));
         e = e | (8'h10 << c);
         crd(6'h0b, e);
      end
      wr(6'h0a, 8'h20);
      #1 chk({7'h00, irqOut}, 8'h01);
      wr(6'h0b, 8'h00);
      crd(6'h0b, 8'h70);
      wr(6'h0b, 8'h10);
      crd(6'h0b, 8'h60);
      wr(6'h20, 8'h20);
      wr(6'h0b, 8'h73);
      crd(6'h0b, 8'h00);
      #1 chk({7'h00, irqOut}, 8'h00);
      wr(6'h0a, 8'h00);
   endtask

   task automatic t_cmd();
      wr(6'h20, 8'h33);
      wr(6'h21, 8'h44);
      wr(6'h05, 8'h09);
      crd(6'h20, 8'h00);
      crd(6'h21, 8'h44);
      crd(6'h05, 8'h01);
      wr(6'h05, 8'h0a);
      crd(6'h21, 8'h00);
      crd(6'h04, 8'h03);
      wr(6'h04, 8'h01);
      crd(6'h05, 8'h02);
      wr(6'h20, 8'h33);
      wr(6'h21, 8'h44);
      wr(6'h05, 8'h07);
      crd(6'h20, 8'h33);
      wr(6'h00, 8'h0f);
      wr(6'h05, 8'h0f);
      wr(6'h00, 8'h00);
      crd(6'h21, 8'h44);
      crd(6'h27, 8'h05);
      wr(6'h05, 8'h0f);
      crd(6'h20, 8'h00);
      crd(6'h21, 8'h00);
      crd(6'h27, 8'hff);
      crd(6'h28, 8'h00);
   endtask

   task automatic t_pins();
      wr(6'h02, 8'h05);
      wr(6'h01, 8'h77);
      #1 chk({2'b00, pins}, 8'h05);
      wr(6'h02, 8'h50);
      @(posedge clk_sys);
      #1 chk({2'b00, pins}, 8'h28);
      wr(6'h01, 8'h07);
      wr(6'h02, 8'h05);
      @(posedge clk_sys);
      #1 chk({2'b00, pins}, 8'h2d);
      @(posedge clk_sys);
      waveGenActive <= 1'b0;
      #1 chk({2'b00, pins}, 8'h2a);
      wr(6'h01, 8'h00);
      waveGenActive <= 1'b1;
   endtask

   task automatic report_and_stop();
      $display("Counts: %0d compared, %0d mismatched", checked, errCount);
      if (errCount == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // The prescaler sweep takes about 11000 cycles and the rest a few hundred.
   initial begin
      repeat (30000) @(posedge clk_sys);
      errCount++;
      report_and_stop();
   end

   initial begin
      rstn = 1'b0;
      bus = '0;
      debugHalt = 1'b0;
      portOutValue = 6'h2a;
      waveGenActive = 1'b1;
      errCount = 0;
      checked = 0;
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      t_regs();
      $display("t_regs done");
      t_prescale();
      $display("t_prescale done");
      t_under();
      $display("t_under done");
      t_compare();
      $display("t_compare done");
      t_cmd();
      $display("t_cmd done");
      t_pins();
      $display("t_pins done");
      report_and_stop();
   end
endmodule // sdt_split_timer_test
